// File: brk_pkg.sv
// Constants for the instruction and data breakpoint unit.
// Assumes the core supplies the coprocessor access stream on the same clock.
//
// Function
// [RL1] The 32-bit instruction breakpoint register holds address and enable.
// [RL2] Bit 0 of the instruction breakpoint register arms it when set.
// [RL3] Bit 1 of the instruction breakpoint register is reserved, no effect.
// [RL4] Bits 31..2 match the fetch address, which must equal the PC.
// [RL5] A matching armed instruction executes, then a prefetch abort follows.
// [RL6] The instruction breakpoint register takes privileged writes only.
// [RL7] The data breakpoint address is compared as a full 32-bit value.
// [RL8] Store data is compared against a 32-bit data breakpoint value.
// [RL9] A one in the 32-bit mask includes that value bit in the comparison.
// [RL10] A store-data breakpoint needs the store address match enabled.
// [RL11] Load breakpoints depend on address match alone.
// [RL12] The enables register has one bit each: load, store, store data.
// [RL13] A data breakpoint hit gives a data abort and sets fault status bit 9.
// [RL14] Data address, value and mask are written only by privileged access.
// [RL15] A data breakpoint stops after the matching access completes.
// [RL16] All breakpoint enables are clear after reset.
// [RL17] Several matches on one access raise only one abort.
package brk_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W = 3;
  // --------------------------------------------------------------
  // Sub-register selects under coprocessor register 14
  // --------------------------------------------------------------
  localparam logic [2:0] SEL_INSTR_BREAK = 3'h0;
  localparam logic [2:0] SEL_DATA_ADDR = 3'h1;
  localparam logic [2:0] SEL_DATA_VALUE = 3'h2;
  localparam logic [2:0] SEL_DATA_MASK = 3'h3;
  localparam logic [2:0] SEL_DATA_ENABLES = 3'h4;
  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int unsigned IB_ENABLE_BIT = 0;
  localparam int unsigned IB_RSVD_BIT = 1;
  localparam int unsigned IB_ADDR_LSB = 2;
  localparam int unsigned EN_W = 3;
  localparam int unsigned EN_LOAD_BIT = 0;
  localparam int unsigned EN_STORE_BIT = 1;
  localparam int unsigned EN_SDATA_BIT = 2;
  localparam int unsigned FAULT_BREAK_BIT = 9;
  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0] RST_ENABLES = 3'h0;
endpackage

// File: brk_if.sv
// Carrier between the breakpoint top and its comparator.
// Assumes both ends sit on one clock; the comparator is purely combinational.
`timescale 1ns/1ps
interface brk_if;
  logic [31:0] instr_break;
  logic [31:0] data_addr;
  logic [31:0] data_value;
  logic [31:0] data_mask;
  logic [2:0] enables;
  logic [31:0] exec_fetch_addr;
  logic [31:0] exec_pc;
  logic [31:0] ls_addr;
  logic [31:0] ls_wdata;
  logic ls_store;
  logic instr_hit;
  logic data_hit;
  modport top (
    output instr_break, data_addr, data_value, data_mask, enables,
    output exec_fetch_addr, exec_pc, ls_addr, ls_wdata, ls_store,
    input instr_hit, data_hit
  );
  modport cmp (
    input instr_break, data_addr, data_value, data_mask, enables,
    input exec_fetch_addr, exec_pc, ls_addr, ls_wdata, ls_store,
    output instr_hit, data_hit
  );
endinterface

// File: brk_match.sv
// Breakpoint comparators: instruction address and data address/value.
// Assumes the top qualifies hits with its valid and completion strobes.
`timescale 1ns/1ps
module brk_match (
  brk_if.cmp bus
);
  logic [31:0] diff;
  logic addr_eq;
  logic data_eq;
  logic ia_eq;

  // [RL9] Masked per-bit compare
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_bit
      assign diff[i] = bus.data_mask[i] &
                       (bus.ls_wdata[i] ^ bus.data_value[i]);
    end
  endgenerate

  // [RL8] Value match
  assign data_eq = (diff == brk_pkg::RST_WORD);
  // [RL7] Full-width address
  assign addr_eq = (bus.ls_addr == bus.data_addr);
  // [RL4] Word compare, fetch equals PC
  assign ia_eq = (bus.exec_fetch_addr[31:brk_pkg::IB_ADDR_LSB] ==
                  bus.instr_break[31:brk_pkg::IB_ADDR_LSB]) &&
                 (bus.exec_fetch_addr == bus.exec_pc);
  // [RL2] Enable gates the instruction hit
  assign bus.instr_hit = ia_eq & bus.instr_break[brk_pkg::IB_ENABLE_BIT];

  // [RL10] Data pattern only adds to the store address match
  always_comb begin
    bus.data_hit = 1'b0;
    if (addr_eq) begin
      if (bus.ls_store) begin
        if (bus.enables[brk_pkg::EN_STORE_BIT]) begin
          bus.data_hit = !bus.enables[brk_pkg::EN_SDATA_BIT] || data_eq;
        end
      end else begin
        // [RL11] Loads on address only
        bus.data_hit = bus.enables[brk_pkg::EN_LOAD_BIT];
      end
    end
  end
endmodule

// File: brk_unit.sv
// Instruction and data breakpoint unit, top level.
// Assumes the core presents completed instructions and completed load/store
// accesses as one-cycle strobes on clk, and that it takes the aborts.
`timescale 1ns/1ps
module brk_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cp_wr_valid,
  input wire logic cp_wr_priv,
  input wire logic [2:0] cp_wr_sel,
  input wire logic [31:0] cp_wr_data,
  input wire logic cp_rd_valid,
  input wire logic cp_rd_priv,
  input wire logic [2:0] cp_rd_sel,
  output logic [31:0] cp_rd_data,
  output logic cp_rd_ack,
  input wire logic exec_valid,
  input wire logic [31:0] exec_fetch_addr,
  input wire logic [31:0] exec_pc,
  input wire logic ls_done,
  input wire logic ls_store,
  input wire logic [31:0] ls_addr,
  input wire logic [31:0] ls_wdata,
  output logic prefetch_abort,
  output logic data_abort,
  output logic fault_break_cause
);
  typedef struct packed {
    logic [31:0] instr_break_addr_ctrl;
    logic [31:0] data_break_address;
    logic [31:0] data_break_value;
    logic [31:0] data_break_mask;
    logic [2:0] data_break_enables;
    logic [31:0] rd_data;
    logic rd_ack;
    logic pabort;
    logic dabort;
    logic fault_bit;
  } state_t;

  state_t state_reg;
  state_t state_next;
  brk_if bus ();

  // --------------------------------------------------------------
  // Comparator
  // --------------------------------------------------------------
  assign bus.instr_break = state_reg.instr_break_addr_ctrl;
  assign bus.data_addr = state_reg.data_break_address;
  assign bus.data_value = state_reg.data_break_value;
  assign bus.data_mask = state_reg.data_break_mask;
  assign bus.enables = state_reg.data_break_enables;
  assign bus.exec_fetch_addr = exec_fetch_addr;
  assign bus.exec_pc = exec_pc;
  assign bus.ls_addr = ls_addr;
  assign bus.ls_wdata = ls_wdata;
  assign bus.ls_store = ls_store;

  brk_match u_match (
    .bus(bus)
  );

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rd_ack = 1'b0;
    // [RL6] Privileged writes only
    if (cp_wr_valid && cp_wr_priv) begin
      case (cp_wr_sel)
        brk_pkg::SEL_INSTR_BREAK: begin
          // [RL1] [RL3] Address plus enable, reserved bit dropped
          state_next.instr_break_addr_ctrl = cp_wr_data;
          state_next.instr_break_addr_ctrl[brk_pkg::IB_RSVD_BIT] = 1'b0;
        end
        // [RL14] Data registers, privileged only
        brk_pkg::SEL_DATA_ADDR: begin
          state_next.data_break_address = cp_wr_data;
        end
        brk_pkg::SEL_DATA_VALUE: begin
          state_next.data_break_value = cp_wr_data;
        end
        brk_pkg::SEL_DATA_MASK: begin
          state_next.data_break_mask = cp_wr_data;
        end
        // [RL12] Three independent enables
        brk_pkg::SEL_DATA_ENABLES: begin
          state_next.data_break_enables = cp_wr_data[2:0];
        end
        default: begin
          state_next.rd_ack = 1'b0;
        end
      endcase
    end
    // Readback, zero for unprivileged or unmapped
    if (cp_rd_valid) begin
      state_next.rd_ack = 1'b1;
      state_next.rd_data = brk_pkg::RST_WORD;
      if (cp_rd_priv) begin
        case (cp_rd_sel)
          brk_pkg::SEL_INSTR_BREAK: begin
            state_next.rd_data = state_reg.instr_break_addr_ctrl;
          end
          brk_pkg::SEL_DATA_ADDR: begin
            state_next.rd_data = state_reg.data_break_address;
          end
          brk_pkg::SEL_DATA_VALUE: begin
            state_next.rd_data = state_reg.data_break_value;
          end
          brk_pkg::SEL_DATA_MASK: begin
            state_next.rd_data = state_reg.data_break_mask;
          end
          brk_pkg::SEL_DATA_ENABLES: begin
            state_next.rd_data = {29'h0000_0000,
                                  state_reg.data_break_enables};
          end
          default: begin
            state_next.rd_data = brk_pkg::RST_WORD;
          end
        endcase
      end
    end
    // [RL5] Abort after the instruction has executed
    state_next.pabort = exec_valid && bus.instr_hit;
    // [RL15] [RL17] One abort after the access completes
    state_next.dabort = ls_done && bus.data_hit;
    // [RL13] Fault cause flagged with the abort
    state_next.fault_bit = ls_done && bus.data_hit;
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // [RL16] Enables cleared at reset
      state_reg.instr_break_addr_ctrl <= brk_pkg::RST_WORD;
      state_reg.data_break_address <= brk_pkg::RST_WORD;
      state_reg.data_break_value <= brk_pkg::RST_WORD;
      state_reg.data_break_mask <= brk_pkg::RST_WORD;
      state_reg.data_break_enables <= brk_pkg::RST_ENABLES;
      state_reg.rd_data <= brk_pkg::RST_WORD;
      state_reg.rd_ack <= 1'b0;
      state_reg.pabort <= 1'b0;
      state_reg.dabort <= 1'b0;
      state_reg.fault_bit <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cp_rd_data = state_reg.rd_data;
  assign cp_rd_ack = state_reg.rd_ack;
  assign prefetch_abort = state_reg.pabort;
  assign data_abort = state_reg.dabort;
  assign fault_break_cause = state_reg.fault_bit;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  logic [31:0] masked_diff;
  assign masked_diff = (ls_wdata ^ state_reg.data_break_value) &
                       state_reg.data_break_mask;

  sequence s_instr_match;
    exec_valid && state_reg.instr_break_addr_ctrl[0] &&
    (exec_fetch_addr[31:2] == state_reg.instr_break_addr_ctrl[31:2]) &&
    (exec_fetch_addr == exec_pc);
  endsequence

  sequence s_load_match;
    ls_done && !ls_store && state_reg.data_break_enables[0] &&
    (ls_addr == state_reg.data_break_address);
  endsequence

  sequence s_store_data_miss;
    ls_done && ls_store && state_reg.data_break_enables[2] &&
    (masked_diff != 32'h0000_0000);
  endsequence

  sequence s_store_match;
    ls_done && ls_store && state_reg.data_break_enables[1] &&
    (ls_addr == state_reg.data_break_address) &&
    (!state_reg.data_break_enables[2] || (masked_diff == 32'h0000_0000));
  endsequence

  property p_instr_abort;
    @(posedge clk) disable iff (!rst_n)
    s_instr_match |=> prefetch_abort;
  endproperty
  a_instr_abort: assert property (p_instr_abort) // [RL5]
    else $error("instruction match without prefetch abort");

  property p_instr_cause;
    @(posedge clk) disable iff (!rst_n)
    prefetch_abort |-> $past(exec_valid) &&
      $past(state_reg.instr_break_addr_ctrl[0]) &&
      ($past(exec_fetch_addr) == $past(exec_pc));
  endproperty
  a_instr_cause: assert property (p_instr_cause) // [RL2]
    else $error("prefetch abort without armed match");

  property p_instr_word;
    @(posedge clk) disable iff (!rst_n)
    prefetch_abort |-> ($past(exec_fetch_addr[31:2]) ==
      $past(state_reg.instr_break_addr_ctrl[31:2]));
  endproperty
  a_instr_word: assert property (p_instr_word) // [RL4]
    else $error("prefetch abort on wrong word address");

  property p_rsvd_bit;
    @(posedge clk) disable iff (!rst_n)
    cp_rd_ack && $past(cp_rd_priv) &&
      ($past(cp_rd_sel) == 3'h0) |-> !cp_rd_data[1];
  endproperty
  a_rsvd_bit: assert property (p_rsvd_bit) // [RL3]
    else $error("reserved instruction breakpoint bit reads set");

  property p_unpriv_write;
    @(posedge clk) disable iff (!rst_n)
    cp_wr_valid && !cp_wr_priv |=>
      $stable(state_reg.instr_break_addr_ctrl) &&
      $stable(state_reg.data_break_address) &&
      $stable(state_reg.data_break_value) &&
      $stable(state_reg.data_break_mask);
  endproperty
  a_unpriv_write: assert property (p_unpriv_write) // [RL6] [RL14]
    else $error("unprivileged write changed a breakpoint register");

  property p_enables_write;
    @(posedge clk) disable iff (!rst_n)
    cp_wr_valid && cp_wr_priv && (cp_wr_sel == 3'h4) |=>
      (state_reg.data_break_enables == $past(cp_wr_data[2:0]));
  endproperty
  a_enables_write: assert property (p_enables_write) // [RL12]
    else $error("enables register not loaded");

  property p_load_abort;
    @(posedge clk) disable iff (!rst_n)
    s_load_match |=> data_abort && fault_break_cause;
  endproperty
  a_load_abort: assert property (p_load_abort) // [RL11] [RL13]
    else $error("load address match without data abort");

  property p_store_needs_addr;
    @(posedge clk) disable iff (!rst_n)
    ls_done && ls_store && !state_reg.data_break_enables[1] |=> !data_abort;
  endproperty
  a_store_needs_addr: assert property (p_store_needs_addr) // [RL10]
    else $error("store abort with store address match disabled");

  property p_store_data_mask;
    @(posedge clk) disable iff (!rst_n)
    s_store_data_miss |=> !data_abort;
  endproperty
  a_store_data_mask: assert property (p_store_data_mask) // [RL8] [RL9]
    else $error("store abort despite masked data mismatch");

  property p_full_addr;
    @(posedge clk) disable iff (!rst_n)
    data_abort |-> ($past(ls_addr) == $past(state_reg.data_break_address));
  endproperty
  a_full_addr: assert property (p_full_addr) // [RL7]
    else $error("data abort without full address match");

  property p_after_access;
    @(posedge clk) disable iff (!rst_n)
    data_abort |-> $past(ls_done) ##1 (!data_abort || $past(ls_done));
  endproperty
  a_after_access: assert property (p_after_access) // [RL15] [RL17]
    else $error("data abort not tied to one completed access");

  property p_fault_pair;
    @(posedge clk) disable iff (!rst_n)
    data_abort == fault_break_cause;
  endproperty
  a_fault_pair: assert property (p_fault_pair) // [RL13]
    else $error("fault cause bit and data abort disagree");

  property p_reset_quiet;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> !prefetch_abort && !data_abort;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) // [RL16]
    else $error("abort right after reset");

  property p_store_abort;
    @(posedge clk) disable iff (!rst_n)
    s_store_match |=> data_abort && fault_break_cause;
  endproperty
  a_store_abort: assert property (p_store_abort) // [RL10] [RL13]
    else $error("store match without data abort");

  property p_instr_disarmed;
    @(posedge clk) disable iff (!rst_n)
    exec_valid && !state_reg.instr_break_addr_ctrl[0] |=> !prefetch_abort;
  endproperty
  a_instr_disarmed: assert property (p_instr_disarmed) // [RL2]
    else $error("prefetch abort while disarmed");

  property p_instr_pc;
    @(posedge clk) disable iff (!rst_n)
    exec_valid && (exec_fetch_addr != exec_pc) |=> !prefetch_abort;
  endproperty
  a_instr_pc: assert property (p_instr_pc) // [RL4]
    else $error("prefetch abort with fetch address off the PC");

  property p_pabort_idle;
    @(posedge clk) disable iff (!rst_n)
    !exec_valid |=> !prefetch_abort;
  endproperty
  a_pabort_idle: assert property (p_pabort_idle) // [RL5]
    else $error("prefetch abort without an executed instruction");

  property p_dabort_idle;
    @(posedge clk) disable iff (!rst_n)
    !ls_done |=> !data_abort;
  endproperty
  a_dabort_idle: assert property (p_dabort_idle) // [RL15]
    else $error("data abort without a completed access");

  property p_instr_write;
    @(posedge clk) disable iff (!rst_n)
    cp_wr_valid && cp_wr_priv && (cp_wr_sel == 3'h0) |=>
      (state_reg.instr_break_addr_ctrl == ($past(cp_wr_data) & 32'hffff_fffd));
  endproperty
  a_instr_write: assert property (p_instr_write) // [RL1] [RL3]
    else $error("instruction breakpoint register not loaded");

  property p_addr_write;
    @(posedge clk) disable iff (!rst_n)
    cp_wr_valid && cp_wr_priv && (cp_wr_sel == 3'h1) |=>
      (state_reg.data_break_address == $past(cp_wr_data));
  endproperty
  a_addr_write: assert property (p_addr_write) // [RL14]
    else $error("data address register not loaded");

  property p_value_write;
    @(posedge clk) disable iff (!rst_n)
    cp_wr_valid && cp_wr_priv && (cp_wr_sel == 3'h2) |=>
      (state_reg.data_break_value == $past(cp_wr_data));
  endproperty
  a_value_write: assert property (p_value_write) // [RL8]
    else $error("data value register not loaded");

  property p_mask_write;
    @(posedge clk) disable iff (!rst_n)
    cp_wr_valid && cp_wr_priv && (cp_wr_sel == 3'h3) |=>
      (state_reg.data_break_mask == $past(cp_wr_data));
  endproperty
  a_mask_write: assert property (p_mask_write) // [RL9]
    else $error("data mask register not loaded");

  property p_unpriv_read;
    @(posedge clk) disable iff (!rst_n)
    cp_rd_valid && !cp_rd_priv |=>
      cp_rd_ack && (cp_rd_data == 32'h0000_0000);
  endproperty
  a_unpriv_read: assert property (p_unpriv_read) // [RL6] [RL14]
    else $error("unprivileged read returned register contents");
endmodule

// File: core_model.sv
// Behavioural core model: coprocessor register traffic and retire strobes.
// Assumes one clock shared with the breakpoint unit; the bench calls tasks.
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  output logic cp_wr_valid,
  output logic cp_wr_priv,
  output logic [2:0] cp_wr_sel,
  output logic [31:0] cp_wr_data,
  output logic cp_rd_valid,
  output logic cp_rd_priv,
  output logic [2:0] cp_rd_sel,
  output logic exec_valid,
  output logic [31:0] exec_fetch_addr,
  output logic [31:0] exec_pc,
  output logic ls_done,
  output logic ls_store,
  output logic [31:0] ls_addr,
  output logic [31:0] ls_wdata
);
  initial begin
    {cp_wr_valid, cp_wr_priv, cp_wr_sel, cp_wr_data} = '0;
    {cp_rd_valid, cp_rd_priv, cp_rd_sel} = '0;
    {exec_valid, exec_fetch_addr, exec_pc} = '0;
    {ls_done, ls_store, ls_addr, ls_wdata} = '0;
  end
  task automatic wr(input logic priv, input logic [2:0] sel,
                    input logic [31:0] data);
    @(posedge clk);
    cp_wr_valid <= 1'b1;
    cp_wr_priv <= priv;
    cp_wr_sel <= sel;
    cp_wr_data <= data;
    @(posedge clk);
    cp_wr_valid <= 1'b0;
    cp_wr_data <= ~data;
  endtask
  task automatic rd(input logic priv, input logic [2:0] sel);
    @(posedge clk);
    cp_rd_valid <= 1'b1;
    cp_rd_priv <= priv;
    cp_rd_sel <= sel;
    @(posedge clk);
    cp_rd_valid <= 1'b0;
  endtask
  task automatic ex(input logic [31:0] fetch, input logic [31:0] pc);
    @(posedge clk);
    exec_valid <= 1'b1;
    exec_fetch_addr <= fetch;
    exec_pc <= pc;
    @(posedge clk);
    exec_valid <= 1'b0;
    exec_fetch_addr <= ~fetch;
    exec_pc <= ~pc;
  endtask
  task automatic ls(input logic st, input logic [31:0] addr,
                    input logic [31:0] wdata);
    @(posedge clk);
    ls_done <= 1'b1;
    ls_store <= st;
    ls_addr <= addr;
    ls_wdata <= wdata;
    @(posedge clk);
    ls_done <= 1'b0;
    ls_addr <= ~addr;
    ls_wdata <= ~wdata;
  endtask
endmodule

// File: tb_brk_unit.sv
// Self-checking bench for the breakpoint unit.
// Assumes core_model drives every request input of the unit.
`timescale 1ns/1ps
module tb_brk_unit;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cp_wr_valid, cp_wr_priv, cp_rd_valid, cp_rd_priv;
  logic [2:0] cp_wr_sel, cp_rd_sel;
  logic [31:0] cp_wr_data, cp_rd_data, exec_fetch_addr, exec_pc;
  logic cp_rd_ack, exec_valid, ls_done, ls_store;
  logic [31:0] ls_addr, ls_wdata;
  logic prefetch_abort, data_abort, fault_break_cause;
  int err_count = 0;
  int tests_run = 0;
  localparam logic [31:0] DA = 32'h4000_0001;
  always #5 clk = ~clk;
  core_model core (.clk(clk), .cp_wr_valid(cp_wr_valid),
    .cp_wr_priv(cp_wr_priv), .cp_wr_sel(cp_wr_sel), .cp_wr_data(cp_wr_data),
    .cp_rd_valid(cp_rd_valid), .cp_rd_priv(cp_rd_priv),
    .cp_rd_sel(cp_rd_sel), .exec_valid(exec_valid),
    .exec_fetch_addr(exec_fetch_addr), .exec_pc(exec_pc),
    .ls_done(ls_done), .ls_store(ls_store), .ls_addr(ls_addr),
    .ls_wdata(ls_wdata));
  brk_unit uut (.clk(clk), .rst_n(rst_n), .cp_wr_valid(cp_wr_valid),
    .cp_wr_priv(cp_wr_priv), .cp_wr_sel(cp_wr_sel), .cp_wr_data(cp_wr_data),
    .cp_rd_valid(cp_rd_valid), .cp_rd_priv(cp_rd_priv),
    .cp_rd_sel(cp_rd_sel), .cp_rd_data(cp_rd_data), .cp_rd_ack(cp_rd_ack),
    .exec_valid(exec_valid), .exec_fetch_addr(exec_fetch_addr),
    .exec_pc(exec_pc), .ls_done(ls_done), .ls_store(ls_store),
    .ls_addr(ls_addr), .ls_wdata(ls_wdata),
    .prefetch_abort(prefetch_abort), .data_abort(data_abort),
    .fault_break_cause(fault_break_cause));
  // ------------------------------------------------------------
  // Compare and report
  // ------------------------------------------------------------
  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Transfer helpers
  // ------------------------------------------------------------
  task automatic rd_chk(input logic priv, input logic [2:0] sel,
                        input logic [31:0] exp);
    core.rd(priv, sel);
    #1;
    chk_bit("cp_rd_ack", 1'b1, cp_rd_ack);
    chk_word("cp_rd_data", exp, cp_rd_data);
    @(posedge clk);
    #1;
    chk_bit("cp_rd_ack_end", 1'b0, cp_rd_ack);
  endtask
  task automatic ex_exp(input logic [31:0] f, input logic [31:0] pc,
                        input logic exp);
    core.ex(f, pc);
    #1;
    chk_bit("prefetch_abort", exp, prefetch_abort);
    @(posedge clk);
    #1;
    chk_bit("prefetch_abort_end", 1'b0, prefetch_abort);
  endtask
  task automatic ls_exp(input logic st, input logic [31:0] a,
                        input logic [31:0] d, input logic exp);
    core.ls(st, a, d);
    #1;
    chk_bit("data_abort", exp, data_abort);
    chk_bit("fault_break_cause", exp, fault_break_cause);
    @(posedge clk);
    #1;
    chk_bit("data_abort_end", 1'b0, data_abort);
    chk_bit("fault_break_cause_end", 1'b0, fault_break_cause);
  endtask
  task automatic en(input logic [2:0] e);
    core.wr(1'b1, brk_pkg::SEL_DATA_ENABLES, {29'h0, e});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 5; i++) rd_chk(1'b1, 3'(i), 32'h0);
    ex_exp(32'h0, 32'h0, 1'b0);
    ls_exp(1'b0, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic t_regs();
    core.wr(1'b1, brk_pkg::SEL_INSTR_BREAK, 32'h1234_5673);
    rd_chk(1'b1, brk_pkg::SEL_INSTR_BREAK, 32'h1234_5671);
    core.wr(1'b0, brk_pkg::SEL_INSTR_BREAK, 32'hffff_ffff);
    rd_chk(1'b1, brk_pkg::SEL_INSTR_BREAK, 32'h1234_5671);
    core.wr(1'b1, brk_pkg::SEL_DATA_ADDR, 32'hdead_beef);
    core.wr(1'b0, brk_pkg::SEL_DATA_ADDR, 32'h0);
    rd_chk(1'b1, brk_pkg::SEL_DATA_ADDR, 32'hdead_beef);
    rd_chk(1'b0, brk_pkg::SEL_DATA_ADDR, 32'h0);
    core.wr(1'b1, brk_pkg::SEL_DATA_VALUE, 32'h0bad_f00d);
    rd_chk(1'b1, brk_pkg::SEL_DATA_VALUE, 32'h0bad_f00d);
    core.wr(1'b1, brk_pkg::SEL_DATA_MASK, 32'hf0f0_0f0f);
    rd_chk(1'b1, brk_pkg::SEL_DATA_MASK, 32'hf0f0_0f0f);
    en(3'h7);
    rd_chk(1'b1, brk_pkg::SEL_DATA_ENABLES, 32'h7);
    core.wr(1'b1, 3'h7, 32'h5555_5555);
    rd_chk(1'b1, 3'h7, 32'h0);
    en(3'h0);
  endtask
  task automatic t_ibrk();
    core.wr(1'b1, brk_pkg::SEL_INSTR_BREAK, 32'h0000_2001);
    ex_exp(32'h2002, 32'h2002, 1'b1);
    ex_exp(32'h2000, 32'h2004, 1'b0);
    ex_exp(32'h2004, 32'h2004, 1'b0);
    ex_exp(32'h8000_2000, 32'h8000_2000, 1'b0);
    core.wr(1'b1, brk_pkg::SEL_INSTR_BREAK, 32'h0000_2002);
    ex_exp(32'h2000, 32'h2000, 1'b0);
  endtask
  task automatic t_dbrk();
    core.wr(1'b1, brk_pkg::SEL_DATA_ADDR, DA);
    core.wr(1'b1, brk_pkg::SEL_DATA_VALUE, 32'ha5a5_0000);
    core.wr(1'b1, brk_pkg::SEL_DATA_MASK, 32'hffff_0000);
    en(3'b001);
    ls_exp(1'b0, DA, 32'h0, 1'b1);
    ls_exp(1'b0, 32'h4000_0000, 32'h0, 1'b0);
    ls_exp(1'b1, DA, 32'h0, 1'b0);
    en(3'b010);
    ls_exp(1'b1, DA, 32'h0, 1'b1);
    ls_exp(1'b0, DA, 32'h0, 1'b0);
    en(3'b110);
    ls_exp(1'b1, DA, 32'ha5a5_1234, 1'b1);
    ls_exp(1'b1, DA, 32'ha4a5_0000, 1'b0);
    en(3'b100);
    ls_exp(1'b1, DA, 32'ha5a5_0000, 1'b0);
    en(3'b111);
    ls_exp(1'b0, DA, 32'h1111_1111, 1'b1);
    ls_exp(1'b1, DA, 32'ha5a5_ffff, 1'b1);
  endtask
  // Arm both breakpoints, then reset in mid-run and expect all cleared
  task automatic t_mid_reset();
    core.wr(1'b1, brk_pkg::SEL_INSTR_BREAK, 32'h0000_0001);
    ex_exp(32'h0, 32'h0, 1'b1);
    en(3'b001);
    ls_exp(1'b0, DA, 32'h0, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_ibrk();
    t_dbrk();
    t_mid_reset();
    wrap_up();
  end
endmodule
